// ===== ocpc_channel.sv
// Output compare and PWM channel with its two time bases
// Notes on behaviour
// - Mode 101 drives pin low at entry, then pulses every compare cycle.
// - Pulse modes raise the pin when count first equals primary value.
// - Pulse modes drop the pin when count equals secondary value.
// - Continuous pulse mode flags an interrupt on every secondary match.
// - Time base reaching its period returns to zero and keeps counting.
// - PWM copies secondary into primary only at period match; primary read-only.
// - Secondary register writes accepted any time without disturbing current period.
// - First PWM period uses the primary value already loaded.
// - Period value N gives a PWM period of N plus one counts.
// - PWM duty zero keeps pin low all period.
// - PWM duty above period keeps pin high continuously.
// - PWM duty equal to period gives one low count per period.
// - Code 111 is PWM with fault honoured, 110 PWM with fault ignored.
// - Code 100 drives pin low at entry then gives exactly one pulse.
// - Code 011 toggles pin on every compare match.
// - Code 010 starts pin high; a match forces it low.
// - Code 001 starts pin low; a match forces it high.
// - Code 000 disables the channel entirely.
// - Fault status bit 4 set on PWM fault, cleared only by hardware.
// - Control bit 3 picks third timer when one, second timer when zero.
// - Control bit 13 set halts the channel while processor is idle.
// - Fault input a governs channels one to four, b five to eight.
// - After single pulse trailing edge, no more pulses; pin held low.
// - Rewriting code 100 re-arms a single pulse without disabling first.
`timescale 1ns/1ps
`default_nettype none

module ocpc_channel
  import ocpc_pkg::*;
#(
  parameter int TW            = 16,
  parameter int CHANNEL_INDEX = 1
)(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [ocpc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  cpu_idle,
  input  wire logic                  fault_input_a,
  input  wire logic                  fault_input_b,
  output logic                       compare_output_pin,
  output logic                       compare_interrupt_flag
);
  import ocpc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (TW < 2 || TW > 16)
  begin : g_bad_width
    $error("time base width must be 2 to 16");
  end
  if (CHANNEL_INDEX < 1 || CHANNEL_INDEX > CHANNELS_MAX)
  begin : g_bad_index
    $error("channel index must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]    mode_r;
  logic          tsel_r;
  logic          idle_stop_r;
  logic          fault_status_r;
  logic [TW-1:0] primary_r;
  logic [TW-1:0] secondary_r;
  logic [1:0]    tb_run_r;
  logic [TW-1:0] period2_r;
  logic [TW-1:0] period3_r;
  logic [TW-1:0] count2_r;
  logic [TW-1:0] count3_r;
  logic          armed_r;
  logic          pin_r;
  logic          flag_r;
  logic [15:0]   rdata_r;

  // Write decode shared by several processes
  function automatic logic hit(input logic [ADDR_W-1:0] idx);
    hit = reg_wr && (reg_addr == idx);
  endfunction : hit

  // Widen a time base value onto the 16-bit data port
  function automatic logic [15:0] widen(input logic [TW-1:0] v);
    widen = 16'(v);
  endfunction : widen

  logic ctl_wr;
  logic [2:0] wr_mode;
  logic is_pwm;
  logic is_pulse;
  assign ctl_wr   = hit(IDX_CONTROL);
  assign wr_mode  = reg_wdata[MODE_LSB +: MODE_W];
  assign is_pwm   = (mode_r == MODE_PWM) || (mode_r == MODE_PWM_FAULT);
  assign is_pulse = (mode_r == MODE_SINGLE) || (mode_r == MODE_CONT);

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  // Selected time base and its period
  logic [TW-1:0] cnt;
  logic [TW-1:0] per;
  logic          tick;
  assign cnt  = tsel_r ? count3_r : count2_r;
  assign per  = tsel_r ? period3_r : period2_r;
  assign tick = tsel_r ? tb_run_r[BIT_RUN_3] : tb_run_r[BIT_RUN_2];

  // Run bits and period registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tb_run_r  <= 2'h0;
      period2_r <= '0;
      period3_r <= '0;
    end
    else
    begin
      if (hit(IDX_TB_CONTROL))
        tb_run_r <= reg_wdata[1:0];
      if (hit(IDX_PERIOD_2))
        period2_r <= reg_wdata[TW-1:0];
      if (hit(IDX_PERIOD_3))
        period3_r <= reg_wdata[TW-1:0];
    end
  end

  // Counters wrap at their period, giving N plus one counts per cycle
  // wrap to zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count2_r <= '0;
      count3_r <= '0;
    end
    else
    begin
      if (hit(IDX_COUNT_2))
        count2_r <= reg_wdata[TW-1:0];
      else if (tb_run_r[BIT_RUN_2])
        count2_r <= (count2_r == period2_r) ? '0 : count2_r + 1'b1;
      if (hit(IDX_COUNT_3))
        count3_r <= reg_wdata[TW-1:0];
      else if (tb_run_r[BIT_RUN_3])
        count3_r <= (count3_r == period3_r) ? '0 : count3_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control register and channel events
  // ----------------------------------------------------------------
  // Channel runs unless told to stop while the processor idles
  logic run_ok;
  logic fault_in;
  logic match_pri;
  logic match_sec;
  logic match_per;
  assign run_ok    = !(idle_stop_r && cpu_idle);
  assign fault_in  = (CHANNEL_INDEX <= FAULT_A_LAST) ? fault_input_a : fault_input_b;
  assign match_pri = run_ok && tick && (cnt == primary_r);
  assign match_sec = run_ok && tick && (cnt == secondary_r);
  assign match_per = run_ok && tick && (cnt == per);

  // Mode, timer select and idle bits; writes land only on implemented bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r      <= MODE_OFF;
      tsel_r      <= 1'b0;
      idle_stop_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      mode_r      <= wr_mode;
      tsel_r      <= reg_wdata[BIT_TSEL];
      idle_stop_r <= reg_wdata[BIT_IDLE_STOP];
    end
  end

  // Fault status: set wins over the hardware clear done on a mode rewrite
  // fault status flag
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fault_status_r <= 1'b0;
    else if (mode_r == MODE_PWM_FAULT && fault_in && run_ok)
      fault_status_r <= 1'b1;
    else if (ctl_wr)
      fault_status_r <= 1'b0;
  end

  // Primary value: software owns it outside PWM, the period match inside
  // duty load at period match
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      primary_r <= '0;
    else if (is_pwm)
    begin
      if (match_per)
        primary_r <= secondary_r;
    end
    else if (hit(IDX_PRIMARY))
      primary_r <= reg_wdata[TW-1:0];
  end

  // Secondary value is a plain buffer; the period match copies it and the pulse modes compare against it
  // writes any time
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      secondary_r <= '0;
    else if (hit(IDX_SECONDARY))
      secondary_r <= reg_wdata[TW-1:0];
  end

  // Single pulse arming; any write of code 100 re-arms
  // re-arm on rewrite
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      armed_r <= 1'b0;
    else if (ctl_wr)
      armed_r <= (wr_mode == MODE_SINGLE);
    else if (mode_r == MODE_SINGLE && match_sec && pin_r)
      armed_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // PWM level from current count; duty zero never high, above period never low
  logic pwm_level;
  assign pwm_level = (primary_r != '0) && (cnt < primary_r);

  // Pin level per mode; entry levels come from the control write itself
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pin_r <= 1'b0;
    else if (ctl_wr)
    begin
      pin_r <= (wr_mode == MODE_SET_LOW);
    end
    else if (mode_r == MODE_OFF)
      pin_r <= 1'b0;
    else if (run_ok)
    begin
      unique case (mode_r)
        MODE_SET_HIGH:
        begin
          if (match_pri)
            pin_r <= 1'b1;
        end
        MODE_SET_LOW:
        begin
          if (match_pri)
            pin_r <= 1'b0;
        end
        MODE_TOGGLE:
        begin
          if (match_pri)
            pin_r <= !pin_r;
        end
        MODE_SINGLE, MODE_CONT:
        begin
          if (match_sec)
            pin_r <= 1'b0;
          else if (match_pri && (mode_r == MODE_CONT || armed_r))
            pin_r <= 1'b1;
          else if (mode_r == MODE_SINGLE && !armed_r)
            pin_r <= 1'b0;
        end
        MODE_PWM:
          pin_r <= pwm_level;
        MODE_PWM_FAULT:
          pin_r <= pwm_level && !fault_in && !fault_status_r;
        default:
          pin_r <= 1'b0;
      endcase
    end
  end

  // Interrupt pulse on compare events, on the trailing match in pulse modes
  // flag every secondary match in continuous pulse mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (ctl_wr || !run_ok)
      flag_r <= 1'b0;
    else
    begin
      unique case (mode_r)
        MODE_SET_HIGH, MODE_SET_LOW, MODE_TOGGLE:
          flag_r <= match_pri;
        MODE_SINGLE:
          flag_r <= match_sec && pin_r;
        MODE_CONT:
          flag_r <= match_sec;
        MODE_PWM:
          flag_r <= match_per;
        MODE_PWM_FAULT:
          flag_r <= match_per || (fault_in && !fault_status_r);
        default:
          flag_r <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe, zero when unmapped
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= RST_WORD;
    else if (!reg_rd)
      rdata_r <= RST_WORD;
    else
    begin
      unique case (reg_addr)
        IDX_CONTROL:
        begin
          rdata_r                          <= RST_WORD;
          rdata_r[BIT_IDLE_STOP]           <= idle_stop_r;
          rdata_r[BIT_FAULT]               <= fault_status_r;
          rdata_r[BIT_TSEL]                <= tsel_r;
          rdata_r[MODE_LSB +: MODE_W]      <= mode_r;
        end
        IDX_PRIMARY:    rdata_r <= widen(primary_r);
        IDX_SECONDARY:  rdata_r <= widen(secondary_r);
        IDX_TB_CONTROL: rdata_r <= {14'h0000, tb_run_r};
        IDX_PERIOD_2:   rdata_r <= widen(period2_r);
        IDX_PERIOD_3:   rdata_r <= widen(period3_r);
        IDX_COUNT_2:    rdata_r <= widen(count2_r);
        IDX_COUNT_3:    rdata_r <= widen(count3_r);
        default:        rdata_r <= RST_WORD;
      endcase
    end
  end

  assign reg_rdata              = rdata_r;
  assign compare_output_pin     = pin_r;
  assign compare_interrupt_flag = flag_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  disabled_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_OFF && !ctl_wr) |=> !pin_r && !flag_r)
    else $error("disabled channel drives pin or flag");

  entry_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ctl_wr && wr_mode == MODE_SET_LOW) |=> pin_r && mode_r == MODE_SET_LOW)
    else $error("set-low mode did not start high");

  pulse_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_CONT && match_pri && !match_sec && !ctl_wr) |=> pin_r)
    else $error("pulse did not rise on primary match");

  cont_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_CONT && match_sec && !ctl_wr) |=> !pin_r && flag_r)
    else $error("continuous pulse fall or flag missing");

  single_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_SINGLE && !armed_r && !ctl_wr)[*2] |=> !pin_r)
    else $error("single pulse repeated after trailing edge");

  duty_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (is_pwm && !ctl_wr) |=> (primary_r == $past(primary_r))
      || ($past(match_per) && primary_r == $past(secondary_r)))
    else $error("duty changed away from period match");

  zero_duty_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_PWM && run_ok && primary_r == '0 && !ctl_wr) |=> !pin_r)
    else $error("zero duty drove pin high");

  full_duty_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_PWM && run_ok && primary_r > per && !ctl_wr) |=> pin_r)
    else $error("duty above period drove pin low");

  fault_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == MODE_PWM_FAULT && fault_in && run_ok && !ctl_wr)
      |=> fault_status_r && !pin_r ##1 (!pin_r || $past(ctl_wr)))
    else $error("fault did not hold pin inactive");

  wrap_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tb_run_r[BIT_RUN_2] && count2_r == period2_r && !hit(IDX_COUNT_2))
      |=> count2_r == '0)
    else $error("time base did not wrap at period");

endmodule : ocpc_channel

`default_nettype wire

// ===== ocpc_pkg.sv
// Package of constants for the output compare and PWM channel
package ocpc_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  IDX_CONTROL     = 4'h0;
  localparam logic [3:0]  IDX_PRIMARY     = 4'h1;
  localparam logic [3:0]  IDX_SECONDARY   = 4'h2;
  localparam logic [3:0]  IDX_TB_CONTROL  = 4'h3;
  localparam logic [3:0]  IDX_PERIOD_2    = 4'h4;
  localparam logic [3:0]  IDX_PERIOD_3    = 4'h5;
  localparam logic [3:0]  IDX_COUNT_2     = 4'h6;
  localparam logic [3:0]  IDX_COUNT_3     = 4'h7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CTL_W           = 16;
  localparam int          BIT_IDLE_STOP   = 13;
  localparam int          BIT_FAULT       = 4;
  localparam int          BIT_TSEL        = 3;
  localparam int          MODE_LSB        = 0;
  localparam int          MODE_W          = 3;
  localparam logic [15:0] CTL_WR_MASK     = 16'h200f;
  localparam int          BIT_RUN_2       = 0;
  localparam int          BIT_RUN_3       = 1;

  // ----------------------------------------------------------------
  // Compare mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_OFF        = 3'h0;
  localparam logic [2:0]  MODE_SET_HIGH   = 3'h1;
  localparam logic [2:0]  MODE_SET_LOW    = 3'h2;
  localparam logic [2:0]  MODE_TOGGLE     = 3'h3;
  localparam logic [2:0]  MODE_SINGLE     = 3'h4;
  localparam logic [2:0]  MODE_CONT       = 3'h5;
  localparam logic [2:0]  MODE_PWM        = 3'h6;
  localparam logic [2:0]  MODE_PWM_FAULT  = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and channel grouping
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam int          FAULT_A_LAST    = 4;
  localparam int          CHANNELS_MAX    = 8;

endpackage : ocpc_pkg

// ===== ocpc_load.sv
// Behavioural load on the compare output: counts high cycles, rises, events
`timescale 1ns/1ps
`default_nettype none

module ocpc_load (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        pin,
  input  wire logic        evt,
  output logic      [15:0] high_cnt,
  output logic      [15:0] rise_cnt,
  output logic      [15:0] evt_cnt
);
  logic pin_prev_r;

  // ----------------------------------------------------------------
  // Observation counters
  // ----------------------------------------------------------------
  // Clear wins; previous level still tracked so no false rise after it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      high_cnt   <= 16'h0000;
      rise_cnt   <= 16'h0000;
      evt_cnt    <= 16'h0000;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin;
      if (clr)
      begin
        high_cnt <= 16'h0000;
        rise_cnt <= 16'h0000;
        evt_cnt  <= 16'h0000;
      end
      else
      begin
        high_cnt <= high_cnt + {15'h0000, pin};
        rise_cnt <= rise_cnt + {15'h0000, pin & ~pin_prev_r};
        evt_cnt  <= evt_cnt + {15'h0000, evt};
      end
    end
  end
endmodule : ocpc_load
`default_nettype wire

// ===== ocpc_channel_tb_top.sv
// Self-checking testbench for the output compare and PWM channel
`timescale 1ns/1ps
`default_nettype none

module ocpc_channel_tb_top;
  import ocpc_pkg::*;

  localparam logic [15:0] PER = 16'h0003;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        cpu_idle  = 1'b0;
  logic        flt_a     = 1'b0;
  logic        flt_b     = 1'b0;
  logic        clr       = 1'b0;
  logic [15:0] reg_rdata;
  logic        pin;
  logic        irq;
  logic [15:0] high_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] evt_cnt;
  logic [15:0] rv;
  logic [15:0] duty [5] = '{16'h2, 16'h0, 16'h3, 16'h5, 16'h1};
  int          failures = 0;
  int          checks   = 0;

  // ----------------------------------------------------------------
  // Clock, design and load
  // ----------------------------------------------------------------
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  ocpc_channel #(.TW(16), .CHANNEL_INDEX(1)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
    .fault_input_a(flt_a), .fault_input_b(flt_b), .compare_output_pin(pin),
    .compare_interrupt_flag(irq));

  ocpc_load load_u (
    .ref_clk(ref_clk), .rst(rst), .clr(clr), .pin(pin), .evt(irq),
    .high_cnt(high_cnt), .rise_cnt(rise_cnt), .evt_cnt(evt_cnt));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // All-ones expectation means the figure is not defined for that window
  task automatic opt(input string what, input logic [15:0] seen, input logic [15:0] exp);
    if (exp !== 16'hffff)
      check(what, seen, exp);
  endtask : opt

  // Strobe is dropped on its own edge so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  task automatic pin_is(input logic exp);
    #1;
    check("output pin", {15'h0000, pin}, {15'h0000, exp});
    @(posedge ref_clk);
  endtask : pin_is

  // Sixteen-cycle observation window, optionally opened by one write
  task automatic win(input int pre, input logic [15:0] h, input logic [15:0] r,
                     input logic [15:0] f, input logic go = 1'b0,
                     input logic [3:0] a = 4'h0, input logic [15:0] d = 16'h0000);
    repeat (pre) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    if (go)
      wr(a, d);
    repeat (go ? 14 : 16) @(posedge ref_clk);
    #1;
    opt("high cycles", high_cnt, h);
    opt("rising edges", rise_cnt, r);
    opt("flag pulses", evt_cnt, f);
    @(posedge ref_clk);
  endtask : win

  task automatic print_verdict;
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(IDX_CONTROL, rv);
    check("control reset", rv, RST_WORD);
    wr(IDX_CONTROL, 16'hffff);
    rd(IDX_CONTROL, rv);
    check("control loose bits", rv, CTL_WR_MASK);
    wr(4'h9, 16'h1234);
    rd(4'h9, rv);
    check("unmapped read", rv, 16'h0000);
    wr(IDX_CONTROL, 16'h0000);
    wr(IDX_PERIOD_2, PER);
    wr(IDX_PERIOD_3, 16'h0007);
    wr(IDX_PRIMARY, 16'h0002);
    wr(IDX_SECONDARY, 16'h0005);
    wr(IDX_CONTROL, {13'h0000, MODE_PWM});
    rd(IDX_PRIMARY, rv);
    check("duty before run", rv, 16'h0002);
    pin_is(1'b1);
    wr(IDX_TB_CONTROL, 16'h0003);
    for (int i = 0; i < 5; i++)
    begin
      wr(IDX_SECONDARY, duty[i]);
      win(6, (duty[i] > PER) ? 16'h10 : 16'(4 * duty[i]),
          (duty[i] == 0 || duty[i] > PER) ? 16'h0 : 16'h4, 16'h4);
      rd(IDX_PRIMARY, rv);
      check("duty reload", rv, duty[i]);
    end
    wr(IDX_PRIMARY, 16'h0009);
    rd(IDX_PRIMARY, rv);
    check("duty read only", rv, 16'h0001);
    repeat (4)
    begin
      rd(IDX_COUNT_2, rv);
      check("count wraps", {15'h0000, rv <= PER}, 16'h0001);
    end
    wr(IDX_SECONDARY, 16'h0002);
    wr(IDX_CONTROL, 16'h000e);
    win(10, 16'h4, 16'h2, 16'h2);
    wr(IDX_CONTROL, {13'h0000, MODE_PWM});
    flt_a <= 1'b1;
    win(6, 16'h8, 16'h4, 16'h4);
    wr(IDX_CONTROL, {13'h0000, MODE_PWM_FAULT});
    // Period-match flags keep coming; the one fault pulse falls before the window
    win(2, 16'h0, 16'h0, 16'h4);
    rd(IDX_CONTROL, rv);
    check("fault status set", rv, 16'h0017);
    flt_a <= 1'b0;
    win(2, 16'h0, 16'h0, 16'h4);
    rd(IDX_CONTROL, rv);
    check("fault status held", rv, 16'h0017);
    wr(IDX_CONTROL, {13'h0000, MODE_PWM_FAULT});
    rd(IDX_CONTROL, rv);
    check("fault status cleared", rv, 16'h0007);
    flt_b <= 1'b1;
    win(6, 16'h8, 16'h4, 16'h4);
    flt_b <= 1'b0;
    wr(IDX_TB_CONTROL, 16'h0000);
    wr(IDX_COUNT_2, 16'h0000);
    wr(IDX_CONTROL, {13'h0000, MODE_CONT});
    pin_is(1'b0);
    wr(IDX_PRIMARY, 16'h0001);
    wr(IDX_TB_CONTROL, 16'h0003);
    win(4, 16'h4, 16'h4, 16'h4);
    wr(IDX_TB_CONTROL, 16'h0000);
    wr(IDX_COUNT_2, 16'h0000);
    wr(IDX_CONTROL, {13'h0000, MODE_SINGLE});
    pin_is(1'b0);
    win(0, 16'h1, 16'h1, 16'h1, 1'b1, IDX_TB_CONTROL, 16'h0003);
    win(0, 16'h1, 16'h1, 16'h1, 1'b1, IDX_CONTROL, 16'h0004);
    wr(IDX_TB_CONTROL, 16'h0000);
    wr(IDX_CONTROL, {13'h0000, MODE_SET_LOW});
    pin_is(1'b1);
    wr(IDX_TB_CONTROL, 16'h0003);
    repeat (8) @(posedge ref_clk);
    pin_is(1'b0);
    wr(IDX_TB_CONTROL, 16'h0000);
    wr(IDX_CONTROL, {13'h0000, MODE_SET_HIGH});
    pin_is(1'b0);
    wr(IDX_TB_CONTROL, 16'h0003);
    repeat (8) @(posedge ref_clk);
    pin_is(1'b1);
    wr(IDX_CONTROL, {13'h0000, MODE_TOGGLE});
    win(4, 16'h8, 16'h2, 16'h4);
    wr(IDX_CONTROL, {13'h0000, MODE_OFF});
    win(2, 16'h0, 16'h0, 16'h0);
    wr(IDX_CONTROL, 16'h2006);
    cpu_idle <= 1'b1;
    win(6, 16'hffff, 16'h0, 16'h0);
    cpu_idle <= 1'b0;
    win(6, 16'h8, 16'h4, 16'h4);
    wr(IDX_CONTROL, {13'h0000, MODE_PWM});
    cpu_idle <= 1'b1;
    win(6, 16'h8, 16'h4, 16'h4);
    cpu_idle <= 1'b0;
    print_verdict();
  end

  // Run needs well under two thousand cycles; this bound stops a hang
  initial
  begin
    #(50 * 6000);
    failures++;
    print_verdict();
  end
endmodule : ocpc_channel_tb_top
`default_nettype wire
